// *** design/isss_defines.vh ***
// Register map, reset values and select codes of the in-line stream sequencer
`ifndef ISSS_DEFINES_VH
`define ISSS_DEFINES_VH

`define ISSS_ADDR_W 8
`define ISSS_DATA_W 16

`define ISSS_OFS_MODE 8'h0b
`define ISSS_OFS_EXP_ROWS 8'h0c
`define ISSS_OFS_ROW_LEN 8'h12
`define ISSS_OFS_GLOB_LEN 8'h14
`define ISSS_OFS_WIN_ENA 8'h1c
`define ISSS_OFS_COMMAND 8'h1e
`define ISSS_OFS_TEST_SEL 8'h32
`define ISSS_OFS_UNSAFE_EN 8'h4c
`define ISSS_OFS_STATUS 8'h4d
`define ISSS_OFS_WIN_BASE 8'h20

`define ISSS_MODE_INLINE 3'h4
`define ISSS_RST_MODE 3'h0
`define ISSS_RST_EXP_ROWS 14'h0001
`define ISSS_RST_ROW_LEN 16'h0064
`define ISSS_RST_GLOB_LEN 16'h0096
`define ISSS_RST_WIN_ENA 16'h0001
`define ISSS_RST_WIN_SIZE 14'h0004
`define ISSS_RST_TEST_SEL 16'h0000
`define ISSS_RST_UNSAFE_EN 1'h0

`define ISSS_CMD_HALT 0
`define ISSS_CMD_SOFT_RST 1

`define ISSS_SEL_A_LSB 5
`define ISSS_SEL_B_LSB 10
`define ISSS_SEL_W 5

`define ISSS_SEL_PLL_LOCK 5'h00
`define ISSS_SEL_GLOB 5'h08
`define ISSS_SEL_EXP_S 5'h09
`define ISSS_SEL_EXP_L 5'h0a
`define ISSS_SEL_OB_VALID 5'h0b
`define ISSS_SEL_STAT_VALID 5'h0c
`define ISSS_SEL_FRAME_VALID 5'h0d
`define ISSS_SEL_LINE_VALID 5'h0e
`define ISSS_SEL_UNSAFE_FRAME 5'h18
`define ISSS_SEL_UNSAFE_EXP 5'h19

`define ISSS_CTRL_W 10
`define ISSS_CTRL_LINE_VALID 0
`define ISSS_CTRL_FRAME_VALID 1
`define ISSS_CTRL_GLOB 2
`define ISSS_CTRL_EXPOSING 3
`define ISSS_CTRL_UNSAFE_EXP 8
`define ISSS_CTRL_UNSAFE_FRAME 9

`endif

// *** design/isss_row_timer.v ***
// Row-period tick generator for the in-line stream sequencer
`timescale 1ns/100ps
`default_nettype none
module isss_row_timer #(
  parameter CNT_W = 16
) (
  input wire clk_in,
  input wire nrst_in,
  input wire restart_in,
  input wire [CNT_W-1:0] row_len_in,
  output reg row_tick_out
);
  reg [CNT_W-1:0] cnt_r;
  wire [CNT_W-1:0] last_w;

  // A zero length is treated as one clock per row
  assign last_w = (row_len_in == {CNT_W{1'b0}}) ? {CNT_W{1'b0}} :
                  row_len_in - {{(CNT_W-1){1'b0}}, 1'b1};

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= {CNT_W{1'b0}};
      row_tick_out <= 1'b0;
    end else if (restart_in) begin
      // Start at one so the first row after a restart is not a clock longer
      cnt_r <= (last_w == {CNT_W{1'b0}}) ? {CNT_W{1'b0}} : {{(CNT_W-1){1'b0}}, 1'b1};
      row_tick_out <= (last_w == {CNT_W{1'b0}});
    end else if (cnt_r >= last_w) begin
      cnt_r <= {CNT_W{1'b0}};
      row_tick_out <= 1'b1;
    end else begin
      cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      row_tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** design/isss_sequencer.v ***
// In-line streaming sequencer with unsafe-request status and test pin multiplexer
//
// Overview of operation
// - Mode field value 4 selects in-line streaming instead of the normal sequence.
// - Stream runs until a non-blocking halt command, soft reset or hard reset.
// - Request rising edge enters global sampling at once, no exposure first.
// - Rows per frame is the sum of enabled vertical window sizes.
// - Next frame is exposed while the current frame is being read.
// - Exposure start is placed by exposure rows relative to total rows.
// - Shutter lag applies at both start and end of exposure by default.
// - With shutter lag on, exposure lasts exposure rows times one row period.
// - Exposure time is always a whole number of row periods.
// - All sequencing after the start advances at the row rate set by the row length.
// - Global sampling is padded with idle time to whole row periods.
// - Dual exposure, sync updates, contexts, statistics, dummy rows stay off.
// - Control word bits 8 and 9 are 0 unless the unsafe enable is set.
// - Unsafe flags rise whenever a new request would be invalid or ignored.
// - While streaming, a set unsafe flag means a request now is ignored.
// - Unsafe flags are seen in the control word or on a test pin.
// - Select field A drives test pins one and three, B drives two and four.
// - Codes 0, 8 to 14 pick lock, glob, exposures, OB, stats, frame, line.
// - Code 24 gives unsafe frame flag, code 25 unsafe exposure flag.
// - Glob test indication covers only the program part of global sampling.
`timescale 1ns/100ps
`default_nettype none
`include "isss_defines.vh"
module isss_sequencer #(
  parameter NUM_WIN = 2,
  parameter ROW_W = 14,
  parameter LEN_W = 16
) (
  input wire clk_in,
  input wire nrst_in,
  input wire [`ISSS_ADDR_W-1:0] reg_addr_in,
  input wire [`ISSS_DATA_W-1:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire exposure_request_in,
  input wire pll_lock_in,
  output reg [`ISSS_DATA_W-1:0] reg_rdata_out,
  output reg [`ISSS_CTRL_W-1:0] control_channel_output_out,
  output reg test_pin_one_out,
  output reg test_pin_two_out,
  output reg test_pin_three_out,
  output reg test_pin_four_out,
  output reg exposing_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_GLOB = 2'h1;
  localparam ST_READ = 2'h2;
  localparam [15:0] RST_WIN_ENA = `ISSS_RST_WIN_ENA;

  reg [2:0] mode_r;
  reg [ROW_W-1:0] exp_rows_r;
  reg [LEN_W-1:0] row_len_r;
  reg [LEN_W-1:0] glob_len_r;
  reg [NUM_WIN-1:0] win_ena_r;
  reg [ROW_W-1:0] win_size_r [0:NUM_WIN-1];
  reg [`ISSS_DATA_W-1:0] test_sel_r;
  reg unsafe_en_r;
  reg halt_pend_r;
  reg soft_rst_r;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [ROW_W-1:0] row_cnt_r;
  reg [ROW_W-1:0] row_cnt_nxt;
  reg [LEN_W-1:0] glob_cnt_r;
  reg glob_prog_r;
  reg req_d_r;
  reg exposing_r;
  reg exposing_nxt;

  wire row_tick_w;
  wire req_rise_w;
  wire inline_w;
  wire timer_restart_w;
  wire [ROW_W-1:0] exp_start_w;
  wire [ROW_W-1:0] total_last_w;
  wire streaming_w;
  wire unsafe_frame_w;
  wire unsafe_exp_w;
  wire [`ISSS_SEL_W-1:0] sel_a_w;
  wire [`ISSS_SEL_W-1:0] sel_b_w;
  wire [ROW_W-1:0] win_sum_w [0:NUM_WIN];

  // Total rows read per frame from the enabled windows
  assign win_sum_w[0] = {ROW_W{1'b0}};
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi = gi + 1) begin : g_win
      assign win_sum_w[gi+1] = win_sum_w[gi] +
        (win_ena_r[gi] ? win_size_r[gi] : {ROW_W{1'b0}});
    end
  endgenerate

  assign total_last_w = (win_sum_w[NUM_WIN] == {ROW_W{1'b0}}) ? {ROW_W{1'b0}} :
                        win_sum_w[NUM_WIN] - {{(ROW_W-1){1'b0}}, 1'b1};
  // Exposure opens this many rows before the frame ends; zero is held to one
  assign exp_start_w = (exp_rows_r == {ROW_W{1'b0}}) ? total_last_w :
                       win_sum_w[NUM_WIN] - exp_rows_r;

  assign inline_w = (mode_r == `ISSS_MODE_INLINE);
  assign req_rise_w = exposure_request_in & ~req_d_r;
  assign streaming_w = (state_r != ST_IDLE);
  // Any request while streaming or outside in-line mode is disregarded
  assign unsafe_frame_w = streaming_w | ~inline_w | soft_rst_r;
  assign unsafe_exp_w = streaming_w | ~inline_w | soft_rst_r | exposing_r;
  assign timer_restart_w = (state_r == ST_IDLE);
  assign sel_a_w = test_sel_r[`ISSS_SEL_A_LSB +: `ISSS_SEL_W];
  assign sel_b_w = test_sel_r[`ISSS_SEL_B_LSB +: `ISSS_SEL_W];

  isss_row_timer #(
    .CNT_W(LEN_W)
  ) u_row_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .restart_in(timer_restart_w),
    .row_len_in(row_len_r),
    .row_tick_out(row_tick_w)
  );

  // Register writes and commands
  integer wi;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_r <= `ISSS_RST_MODE;
      exp_rows_r <= `ISSS_RST_EXP_ROWS;
      row_len_r <= `ISSS_RST_ROW_LEN;
      glob_len_r <= `ISSS_RST_GLOB_LEN;
      win_ena_r <= RST_WIN_ENA[NUM_WIN-1:0];
      test_sel_r <= `ISSS_RST_TEST_SEL;
      unsafe_en_r <= `ISSS_RST_UNSAFE_EN;
      soft_rst_r <= 1'b0;
      for (wi = 0; wi < NUM_WIN; wi = wi + 1) begin
        win_size_r[wi] <= `ISSS_RST_WIN_SIZE;
      end
    end else begin
      soft_rst_r <= 1'b0;
      if (reg_wr_in) begin
        case (reg_addr_in)
          `ISSS_OFS_MODE: mode_r <= reg_wdata_in[2:0];
          `ISSS_OFS_EXP_ROWS: exp_rows_r <= reg_wdata_in[ROW_W-1:0];
          `ISSS_OFS_ROW_LEN: row_len_r <= reg_wdata_in[LEN_W-1:0];
          `ISSS_OFS_GLOB_LEN: glob_len_r <= reg_wdata_in[LEN_W-1:0];
          `ISSS_OFS_WIN_ENA: win_ena_r <= reg_wdata_in[NUM_WIN-1:0];
          `ISSS_OFS_TEST_SEL: test_sel_r <= reg_wdata_in;
          `ISSS_OFS_UNSAFE_EN: unsafe_en_r <= reg_wdata_in[0];
          `ISSS_OFS_COMMAND: soft_rst_r <= reg_wdata_in[`ISSS_CMD_SOFT_RST];
          default: begin
            for (wi = 0; wi < NUM_WIN; wi = wi + 1) begin
              if (reg_addr_in == `ISSS_OFS_WIN_BASE + wi[`ISSS_ADDR_W-1:0]) begin
                win_size_r[wi] <= reg_wdata_in[ROW_W-1:0];
              end
            end
          end
        endcase
      end
    end
  end

  // Register reads, unmapped offsets return zero
  integer ri;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= {`ISSS_DATA_W{1'b0}};
    end else if (reg_rd_in) begin
      reg_rdata_out <= {`ISSS_DATA_W{1'b0}};
      case (reg_addr_in)
        `ISSS_OFS_MODE: reg_rdata_out[2:0] <= mode_r;
        `ISSS_OFS_EXP_ROWS: reg_rdata_out[ROW_W-1:0] <= exp_rows_r;
        `ISSS_OFS_ROW_LEN: reg_rdata_out[LEN_W-1:0] <= row_len_r;
        `ISSS_OFS_GLOB_LEN: reg_rdata_out[LEN_W-1:0] <= glob_len_r;
        `ISSS_OFS_WIN_ENA: reg_rdata_out[NUM_WIN-1:0] <= win_ena_r;
        `ISSS_OFS_TEST_SEL: reg_rdata_out <= test_sel_r;
        `ISSS_OFS_UNSAFE_EN: reg_rdata_out[0] <= unsafe_en_r;
        `ISSS_OFS_STATUS: begin
          reg_rdata_out[1:0] <= state_r;
          reg_rdata_out[2] <= exposing_r;
          reg_rdata_out[3] <= unsafe_frame_w;
          reg_rdata_out[4] <= unsafe_exp_w;
          reg_rdata_out[5] <= halt_pend_r;
        end
        default: begin
          for (ri = 0; ri < NUM_WIN; ri = ri + 1) begin
            if (reg_addr_in == `ISSS_OFS_WIN_BASE + ri[`ISSS_ADDR_W-1:0]) begin
              reg_rdata_out[ROW_W-1:0] <= win_size_r[ri];
            end
          end
        end
      endcase
    end
  end

  // Halt is non-blocking: the running frame is finished first
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      halt_pend_r <= 1'b0;
    end else if (soft_rst_r || state_r == ST_IDLE) begin
      halt_pend_r <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == `ISSS_OFS_COMMAND &&
                 reg_wdata_in[`ISSS_CMD_HALT]) begin
      halt_pend_r <= 1'b1;
    end
  end

  // Sequencer next state, advancing only on row ticks except the start
  always @* begin
    state_nxt = state_r;
    row_cnt_nxt = row_cnt_r;
    exposing_nxt = exposing_r;
    case (state_r)
      ST_IDLE: begin
        exposing_nxt = 1'b0;
        row_cnt_nxt = {ROW_W{1'b0}};
        if (req_rise_w && inline_w) begin
          state_nxt = ST_GLOB;
        end
      end
      ST_GLOB: begin
        // Program done and row boundary reached ends the padded phase
        if (row_tick_w && !glob_prog_r) begin
          state_nxt = ST_READ;
          row_cnt_nxt = {ROW_W{1'b0}};
          exposing_nxt = (exp_start_w == {ROW_W{1'b0}});
        end
      end
      ST_READ: begin
        if (row_tick_w) begin
          if (row_cnt_r >= total_last_w) begin
            // Exposure closes as global sampling begins
            exposing_nxt = 1'b0;
            row_cnt_nxt = {ROW_W{1'b0}};
            state_nxt = halt_pend_r ? ST_IDLE : ST_GLOB;
          end else begin
            row_cnt_nxt = row_cnt_r + {{(ROW_W-1){1'b0}}, 1'b1};
            if (row_cnt_nxt == exp_start_w && !halt_pend_r) begin
              exposing_nxt = 1'b1;
            end
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= ST_IDLE;
      row_cnt_r <= {ROW_W{1'b0}};
      exposing_r <= 1'b0;
      req_d_r <= 1'b0;
    end else if (soft_rst_r) begin
      state_r <= ST_IDLE;
      row_cnt_r <= {ROW_W{1'b0}};
      exposing_r <= 1'b0;
      req_d_r <= exposure_request_in;
    end else begin
      state_r <= state_nxt;
      row_cnt_r <= row_cnt_nxt;
      exposing_r <= exposing_nxt;
      req_d_r <= exposure_request_in;
    end
  end

  // Word-generator program run inside global sampling
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      glob_cnt_r <= {LEN_W{1'b0}};
      glob_prog_r <= 1'b0;
    end else if (state_r != ST_GLOB && state_nxt == ST_GLOB && !soft_rst_r) begin
      glob_cnt_r <= glob_len_r;
      glob_prog_r <= (glob_len_r != {LEN_W{1'b0}});
    end else if (glob_prog_r) begin
      glob_cnt_r <= glob_cnt_r - {{(LEN_W-1){1'b0}}, 1'b1};
      if (glob_cnt_r <= {{(LEN_W-1){1'b0}}, 1'b1}) begin
        glob_prog_r <= 1'b0;
      end
    end
  end

  // Test pin source for one select code
  function mux_sel;
    input [`ISSS_SEL_W-1:0] sel;
    input [1:0] st;
    input prog;
    input expo;
    input lock;
    input uf;
    input ue;
    begin
      case (sel)
        `ISSS_SEL_PLL_LOCK: mux_sel = lock;
        `ISSS_SEL_GLOB: mux_sel = (st == ST_GLOB) & prog;
        `ISSS_SEL_EXP_S: mux_sel = expo;
        `ISSS_SEL_EXP_L: mux_sel = expo;
        `ISSS_SEL_OB_VALID: mux_sel = (st == ST_READ);
        `ISSS_SEL_STAT_VALID: mux_sel = 1'b0;
        `ISSS_SEL_FRAME_VALID: mux_sel = (st == ST_READ);
        `ISSS_SEL_LINE_VALID: mux_sel = (st == ST_READ);
        `ISSS_SEL_UNSAFE_FRAME: mux_sel = uf;
        `ISSS_SEL_UNSAFE_EXP: mux_sel = ue;
        default: mux_sel = 1'b0;
      endcase
    end
  endfunction

  // Registered outputs: control word, test pins, exposure status
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      control_channel_output_out <= {`ISSS_CTRL_W{1'b0}};
      test_pin_one_out <= 1'b0;
      test_pin_two_out <= 1'b0;
      test_pin_three_out <= 1'b0;
      test_pin_four_out <= 1'b0;
      exposing_out <= 1'b0;
    end else begin
      control_channel_output_out <= {`ISSS_CTRL_W{1'b0}};
      control_channel_output_out[`ISSS_CTRL_LINE_VALID] <= (state_r == ST_READ);
      control_channel_output_out[`ISSS_CTRL_FRAME_VALID] <= (state_r == ST_READ);
      control_channel_output_out[`ISSS_CTRL_GLOB] <= (state_r == ST_GLOB);
      control_channel_output_out[`ISSS_CTRL_EXPOSING] <= exposing_r;
      control_channel_output_out[`ISSS_CTRL_UNSAFE_EXP] <= unsafe_en_r & unsafe_exp_w;
      control_channel_output_out[`ISSS_CTRL_UNSAFE_FRAME] <= unsafe_en_r & unsafe_frame_w;
      test_pin_one_out <= mux_sel(sel_a_w, state_r, glob_prog_r, exposing_r, pll_lock_in,
                                  unsafe_frame_w, unsafe_exp_w);
      test_pin_three_out <= mux_sel(sel_a_w, state_r, glob_prog_r, exposing_r, pll_lock_in,
                                    unsafe_frame_w, unsafe_exp_w);
      test_pin_two_out <= mux_sel(sel_b_w, state_r, glob_prog_r, exposing_r, pll_lock_in,
                                  unsafe_frame_w, unsafe_exp_w);
      test_pin_four_out <= mux_sel(sel_b_w, state_r, glob_prog_r, exposing_r, pll_lock_in,
                                   unsafe_frame_w, unsafe_exp_w);
      exposing_out <= exposing_r;
    end
  end
endmodule
`default_nettype wire

// *** test/isss_cam_model.sv ***
// Camera controller and control channel receiver model
`timescale 1ns/100ps
`default_nettype none
module isss_cam_model (
  input wire logic clk_in,
  input wire logic fire_in,
  input wire logic [9:0] ctrl_in,
  input wire logic exposing_in,
  output logic exposure_request_out,
  output logic [15:0] glob_w_out,
  output logic [15:0] exp_w_out,
  output logic [15:0] fval_w_out
);
  logic [2:0][15:0] cnt_r = '0;
  logic [2:0][15:0] wid_r = '0;
  wire [2:0] mon = {ctrl_in[1], exposing_in, ctrl_in[2]};
  assign glob_w_out = wid_r[0];
  assign exp_w_out = wid_r[1];
  assign fval_w_out = wid_r[2];
  initial exposure_request_out = 1'b0;
  // Request level follows the controller command
  always @(negedge clk_in) exposure_request_out <= fire_in;
  // Last completed width of glob, exposure and frame valid
  always @(posedge clk_in) begin
    for (int i = 0; i < 3; i++) begin
      if (mon[i]) begin
        cnt_r[i] <= cnt_r[i] + 16'h0001;
      end else if (cnt_r[i] != 16'h0000) begin
        wid_r[i] <= cnt_r[i];
        cnt_r[i] <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/isss_seq_chk.sv ***
// Port assertions of the in-line stream sequencer
`timescale 1ns/100ps
`default_nettype none
`include "isss_defines.vh"
module isss_seq_chk (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [`ISSS_ADDR_W-1:0] reg_addr_in,
  input wire logic [`ISSS_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic exposure_request_in,
  input wire logic pll_lock_in,
  input wire logic [`ISSS_CTRL_W-1:0] control_channel_output_out,
  input wire logic test_pin_one_out,
  input wire logic test_pin_two_out,
  input wire logic test_pin_three_out,
  input wire logic test_pin_four_out
);
  logic en_r;
  logic [2:0] mode_r;
  logic [15:0] sel_r;
  wire [4:0] sel_a = sel_r[9:5];
  wire [4:0] sel_b = sel_r[14:10];
  wire [9:0] cc = control_channel_output_out;
  // Shadow of the registers the checks depend on
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_r <= 1'h0;
      mode_r <= 3'h0;
      sel_r <= 16'h0000;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `ISSS_OFS_UNSAFE_EN: en_r <= reg_wdata_in[0];
        `ISSS_OFS_MODE: mode_r <= reg_wdata_in[2:0];
        `ISSS_OFS_TEST_SEL: sel_r <= reg_wdata_in;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_pins_ac_pair: assert property (test_pin_one_out == test_pin_three_out)
    else $error("pins one and three differ");
  a_pins_bd_pair: assert property (test_pin_two_out == test_pin_four_out)
    else $error("pins two and four differ");
  a_unsafe_masked: assert property (!en_r && !$past(en_r) && !$past(en_r, 2) |-> cc[9:8] == 2'h0)
    else $error("unsafe bits set while disabled");
  a_lock_pin_route: assert property ($past(nrst_in) && $past(nrst_in, 2) &&
    $past(sel_a) == `ISSS_SEL_PLL_LOCK |-> test_pin_one_out == $past(pll_lock_in))
    else $error("lock not routed to pin one");
  a_glob_pin_within: assert property ($past(sel_a) == `ISSS_SEL_GLOB && test_pin_one_out |-> cc[2])
    else $error("glob pin high outside global sampling");
  a_frame_pin_route: assert property ($past(sel_b) == `ISSS_SEL_FRAME_VALID |-> test_pin_two_out == cc[1])
    else $error("frame valid pin mismatch");
  a_unsafe_pin_route: assert property ($past(sel_b) == `ISSS_SEL_UNSAFE_FRAME && en_r &&
    $past(en_r) && $past(en_r, 2) |-> test_pin_two_out == cc[9])
    else $error("unsafe frame pin mismatch");
  a_req_to_glob: assert property ($rose(exposure_request_in) && en_r && $past(en_r) &&
    $past(en_r, 2) && mode_r == `ISSS_MODE_INLINE && !cc[9] |-> ##[2:3] cc[2])
    else $error("request did not start global sampling");
endmodule
bind isss_sequencer isss_seq_chk i_chk (
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in),
  .exposure_request_in(exposure_request_in),
  .pll_lock_in(pll_lock_in),
  .control_channel_output_out(control_channel_output_out),
  .test_pin_one_out(test_pin_one_out),
  .test_pin_two_out(test_pin_two_out),
  .test_pin_three_out(test_pin_three_out),
  .test_pin_four_out(test_pin_four_out)
);
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench of the in-line stream sequencer
`timescale 1ns/100ps
`default_nettype none
`include "isss_defines.vh"
module tb;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic pll_lock_in = 1'b0;
  logic fire = 1'b0;
  logic exposure_request_in, t1, t2, t3, t4, exposing_out, e;
  logic [9:0] cc;
  logic [15:0] reg_rdata_out, glob_w, exp_w, fval_w, d;
  int fails = 0;
  int n_compared = 0;
  int glob_age = 0;
  logic [23:0] rows [12] = '{24'h0b0000, 24'h0c0001, 24'h120064, 24'h140096, 24'h1c0001,
    24'h200004, 24'h210004, 24'h320000, 24'h4c0000, 24'h1e0000, 24'h400000, 24'h4d0018};
  logic [4:0] codes [10] = '{5'h00, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h18,
    5'h19};
  always #5 clk_in = ~clk_in;
  // Clocks spent in global sampling so far
  always @(posedge clk_in) glob_age <= cc[2] ? glob_age + 1 : 0;
  isss_sequencer i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .exposure_request_in(exposure_request_in), .pll_lock_in(pll_lock_in),
    .reg_rdata_out(reg_rdata_out), .control_channel_output_out(cc), .test_pin_one_out(t1),
    .test_pin_two_out(t2), .test_pin_three_out(t3), .test_pin_four_out(t4),
    .exposing_out(exposing_out));
  isss_cam_model i_cam (.clk_in(clk_in), .fire_in(fire), .ctrl_in(cc),
    .exposing_in(exposing_out), .exposure_request_out(exposure_request_in),
    .glob_w_out(glob_w), .exp_w_out(exp_w), .fval_w_out(fval_w));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    reg_addr_in = a;
    reg_wdata_in = v;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    @(negedge clk_in);
    d = reg_rdata_out;
  endtask
  task automatic wait_bit(input int i, input logic v);
    int k = 0;
    while (cc[i] !== v && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    if (k == 3000) begin
      fails++;
      $display("ERROR %0t: timeout on control bit %0d", $time, i);
      end_of_test;
    end
  endtask
  function automatic logic pin_exp(input logic [4:0] c);
    case (c)
      5'h00: return pll_lock_in;
      5'h08: return cc[2] && glob_age < 15;
      5'h09, 5'h0a: return cc[3];
      5'h0b, 5'h0d: return cc[1];
      5'h0e: return cc[0];
      5'h18: return cc[9];
      5'h19: return cc[8];
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    repeat (4) @(negedge clk_in);
    nrst_in = 1'b1;
    pll_lock_in = 1'b1;
    repeat (2) @(negedge clk_in);
    foreach (rows[i]) begin
      rd(rows[i][23:16]);
      chk(d, rows[i][15:0]);
    end
    chk(cc, 10'h000);
    // Dual exposure, statistics and dummy rows are never enabled here
    wr(`ISSS_OFS_ROW_LEN, 16'h000a);
    wr(`ISSS_OFS_GLOB_LEN, 16'h000f);
    wr(`ISSS_OFS_EXP_ROWS, 16'h0003);
    wr(`ISSS_OFS_UNSAFE_EN, 16'h0001);
    wr(`ISSS_OFS_TEST_SEL, 16'h6100);
    fire = 1'b1;
    repeat (40) @(negedge clk_in);
    chk(cc[2], 1'b0);
    chk(cc[9:8], 2'h3);
    fire = 1'b0;
    wr(`ISSS_OFS_MODE, 16'h0004);
    chk(cc[9:8], 2'h0);
    fire = 1'b1;
    wait_bit(2, 1'b1);
    chk(exposing_out, 1'b0);
    chk(cc[9:8], 2'h3);
    wait_bit(1, 1'b1);
    repeat (2) @(negedge clk_in);
    chk(glob_w, 16'h0014);
    wait_bit(1, 1'b0);
    wait_bit(1, 1'b1);
    repeat (25) @(negedge clk_in);
    chk({cc[1], exposing_out}, 2'h3);
    wait_bit(1, 1'b0);
    repeat (2) @(negedge clk_in);
    chk(glob_w, 16'h0014);
    chk(exp_w, 16'h001e);
    chk(fval_w, 16'h0028);
    foreach (codes[i]) begin
      wr(`ISSS_OFS_TEST_SEL, {1'b0, codes[i], codes[i], 5'h00});
      repeat (2) @(negedge clk_in);
      e = pin_exp(codes[i]);
      chk({t1, t2, t3, t4}, {4{e}});
    end
    // Program part of global sampling only
    wr(`ISSS_OFS_TEST_SEL, 16'h0100);
    wait_bit(2, 1'b0);
    wait_bit(2, 1'b1);
    chk(t1, 1'b1);
    repeat (17) @(negedge clk_in);
    chk({cc[2], t1}, 2'h2);
    wr(`ISSS_OFS_UNSAFE_EN, 16'h0000);
    chk(cc[9:8], 2'h0);
    wait_bit(1, 1'b0);
    wait_bit(1, 1'b1);
    wr(`ISSS_OFS_COMMAND, 16'h0001);
    rd(`ISSS_OFS_STATUS);
    chk(d[5], 1'b1);
    repeat (10) @(negedge clk_in);
    chk(exposing_out, 1'b0);
    repeat (200) @(negedge clk_in);
    rd(`ISSS_OFS_STATUS);
    chk(d[2:0], 3'h0);
    chk(cc[2:0], 3'h0);
    fire = 1'b0;
    repeat (3) @(negedge clk_in);
    fire = 1'b1;
    wait_bit(2, 1'b1);
    wr(`ISSS_OFS_COMMAND, 16'h0002);
    rd(`ISSS_OFS_STATUS);
    chk(d[1:0], 2'h0);
    rd(`ISSS_OFS_EXP_ROWS);
    chk(d, 16'h0003);
    // Hard reset while streaming
    fire = 1'b0;
    repeat (3) @(negedge clk_in);
    fire = 1'b1;
    wait_bit(2, 1'b1);
    nrst_in = 1'b0;
    @(negedge clk_in);
    chk({cc, exposing_out}, 11'h000);
    nrst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rd(`ISSS_OFS_EXP_ROWS);
    chk(d, 16'h0001);
    // Two windows of 4 and 2 rows, default row and program lengths
    wr(`ISSS_OFS_MODE, 16'h0004);
    wr(`ISSS_OFS_WIN_ENA, 16'h0003);
    wr(`ISSS_OFS_WIN_BASE + 8'h01, 16'h0002);
    fire = 1'b0;
    repeat (3) @(negedge clk_in);
    fire = 1'b1;
    wait_bit(1, 1'b1);
    wait_bit(1, 1'b0);
    repeat (2) @(negedge clk_in);
    chk(fval_w, 16'h0258);
    chk(exp_w, 16'h0064);
    end_of_test;
  end
endmodule
`default_nettype wire
